// >>> verilog/bgd_pkg.sv
// Package for the gate drive conditioning block: register map, fields, types
`default_nettype none
package bgd_pkg;
	// ------------------------------------------------------------
	// Register word addresses (one 32-bit word each)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_MASK_EN = 4'h0;
	localparam logic [3:0] ADDR_MASK_VAL = 4'h1;
	localparam logic [3:0] ADDR_DEAD_TIME = 4'h2;
	localparam logic [3:0] ADDR_POLARITY = 4'h3;
	localparam logic [3:0] ADDR_MODE_CTRL = 4'h4;
	localparam logic [3:0] ADDR_HALL_CTRL = 4'h5;
	localparam logic [3:0] ADDR_HALL_FILT = 4'h6;
	localparam logic [3:0] ADDR_STATUS = 4'h7;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int DT_CLK_LSB = 6;
	localparam int DT_EN_BIT = 5;
	localparam int MODE_MASK_SEL = 0;
	localparam int MODE_BRAKE = 1;
	localparam int MODE_PROT_SEL = 2;
	localparam int MODE_SOFT_C = 3;
	localparam int HC_SRC_MODE = 0;
	localparam int HC_SRC_SEL = 1;
	localparam int HC_FILT_EN = 2;
	localparam int HC_DELAY_SEL = 3;
	localparam int HC_TMR_LSB = 4;
	localparam int HC_SOFT_LSB = 6;
	localparam int HF_RATE_LSB = 5;
	localparam logic [1:0] TMR_UNUSED = 2'h3;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} bgd_gate_s;
	typedef enum logic [2:0] {
		DT_IDLE = 3'b001,
		DT_WAIT = 3'b010,
		DT_HIGH = 3'b100
	} bgd_dt_e;
endpackage
`default_nettype wire

// >>> verilog/bgd_top.sv
// Gate drive conditioning and Hall front end with Avalon-MM registers
//
// Functional notes
// - Mask-enable bit set blocks generator signal; channel drives its mask value.
// - Masked channel: mask value 0 drives low, 1 drives high.
// - Brake overrides all: highs 0, lows 1.
// - Protection forces outputs: select 0 all off, select 1 brake pattern.
// - Rising edges delayed by dead time when enabled.
// - Falling edges pass without added delay.
// - Dead-time clock: system clock divided by 1, 2, 4 or 8.
// - Dead-time enable 0 passes edges undelayed.
// - Dead time is (count plus one) times dead-time clock period.
// - Both sides of a pair high forces that pair to 0.
// - One polarity bit per gate output; 1 inverts; bit 0 phase A high.
// - Gate pins high impedance after reset.
// - A 1 on a gate signal turns the transistor on.
// - Hall source bit 0 uses software bits, 1 uses selected Hall inputs.
// - Filter enable 0 bypasses noise filter, 1 filters Hall inputs.
// - Filter samples at selected rate, accepts level after compare count samples.
// - Delay select 0 clears both delay buffers and bypasses delay.
// - Delay select 1: hardware drives chosen timer's run bit.
// - Software mask applies only when mask-mode select is 1.
// - Both channels of pair masked with values 1 forces pair to 0.
// - Timer select: 00 first, 01 second, 10 third timer, 11 unused.
`timescale 1ns/1ps
`default_nettype none
module bgd_top
	import bgd_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic [5:0] pwm_gen_in,
	input wire logic [5:0] hw_mask_in,
	input wire logic protect_in,
	input wire logic [2:0] hall_pin_in,
	input wire logic [2:0] hall_cmp_in,
	input wire logic timer_match_in,
	output logic [2:0] gate_high_pins_out,
	output logic [2:0] gate_low_pins_out,
	output logic [5:0] gate_oe_out,
	output logic [2:0] hall_decode_out,
	output logic [2:0] timer_run_bit_out
);
	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [7:0] mask_en_q, mask_en_d, mask_val_q, mask_val_d;
	logic [7:0] dts_q, dts_d, pol_q, pol_d, mode_q, mode_d;
	logic [7:0] hctl_q, hctl_d, hflt_q, hflt_d;
	logic ack_q, ack_d, oe_q, oe_d;
	logic [31:0] rdata_q, rdata_d;
	logic [2:0] hall_sel;
	logic [2:0] filt_q, filt_d;
	logic hall_st;

	function automatic logic [7:0] wr_byte(input logic [7:0] cur, input logic en,
		input logic [7:0] nv);
		wr_byte = en ? nv : cur;
	endfunction

	always_comb begin
		logic hit;
		// Write lands only at the edge where waitrequest is low
		hit = avs_write_in && ack_q;
		mask_en_d = mask_en_q;
		mask_val_d = mask_val_q;
		dts_d = dts_q;
		pol_d = pol_q;
		mode_d = mode_q;
		hctl_d = hctl_q;
		hflt_d = hflt_q;
		oe_d = oe_q;
		ack_d = (avs_read_in || avs_write_in) && !ack_q;
		rdata_d = rdata_q;
		if (hit) begin
			unique case (avs_address_in)
				ADDR_MASK_EN: mask_en_d = wr_byte(mask_en_q, avs_byteenable_in[0],
					{2'h0, avs_writedata_in[5:0]});
				ADDR_MASK_VAL: mask_val_d = wr_byte(mask_val_q, avs_byteenable_in[0],
					{2'h0, avs_writedata_in[5:0]});
				ADDR_DEAD_TIME: dts_d = wr_byte(dts_q, avs_byteenable_in[0],
					avs_writedata_in[7:0]);
				ADDR_POLARITY: pol_d = wr_byte(pol_q, avs_byteenable_in[0],
					{2'h0, avs_writedata_in[5:0]});
				ADDR_MODE_CTRL: mode_d = wr_byte(mode_q, avs_byteenable_in[0],
					{4'h0, avs_writedata_in[3:0]});
				ADDR_HALL_CTRL: hctl_d = wr_byte(hctl_q, avs_byteenable_in[0],
					avs_writedata_in[7:0]);
				ADDR_HALL_FILT: hflt_d = wr_byte(hflt_q, avs_byteenable_in[0],
					avs_writedata_in[7:0]);
				default: ;
			endcase
			// Pins leave high impedance once software programs polarity
			if (avs_address_in == ADDR_POLARITY) oe_d = 1'b1;
		end
		if (avs_read_in && !ack_q) begin
			unique case (avs_address_in)
				ADDR_MASK_EN: rdata_d = {24'h0, mask_en_q};
				ADDR_MASK_VAL: rdata_d = {24'h0, mask_val_q};
				ADDR_DEAD_TIME: rdata_d = {24'h0, dts_q};
				ADDR_POLARITY: rdata_d = {24'h0, pol_q};
				ADDR_MODE_CTRL: rdata_d = {24'h0, mode_q};
				ADDR_HALL_CTRL: rdata_d = {24'h0, hctl_q};
				ADDR_HALL_FILT: rdata_d = {24'h0, hflt_q};
				ADDR_STATUS: rdata_d = {24'h0, 1'b0, gate_high_pins_out[0],
					gate_low_pins_out[0], gate_high_pins_out[1], 1'b0, hall_decode_out};
				default: rdata_d = UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mask_en_q <= RESET_BYTE;
			mask_val_q <= RESET_BYTE;
			dts_q <= RESET_BYTE;
			pol_q <= RESET_BYTE;
			mode_q <= RESET_BYTE;
			hctl_q <= RESET_BYTE;
			hflt_q <= RESET_BYTE;
			ack_q <= 1'b0;
			oe_q <= 1'b0;
			rdata_q <= UNMAPPED_DATA;
		end else begin
			mask_en_q <= mask_en_d;
			mask_val_q <= mask_val_d;
			dts_q <= dts_d;
			pol_q <= pol_d;
			mode_q <= mode_d;
			hctl_q <= hctl_d;
			hflt_q <= hflt_d;
			ack_q <= ack_d;
			oe_q <= oe_d;
			rdata_q <= rdata_d;
		end
	end

	// Answer one cycle after the request is seen
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
	assign avs_readdata_out = rdata_q;

	// ------------------------------------------------------------
	// Mask stage and overrides
	// ------------------------------------------------------------
	// Channel n: even = high side, odd = low side of pair n/2
	logic [5:0] soft_mask, mask_out, ovr_out;
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			for (int s = 0; s < 2; s++) begin
				soft_mask[2*p+s] = mask_en_q[2*p+s] ? mask_val_q[2*p+s]
					: pwm_gen_in[2*p+s];
			end
			if (mask_en_q[2*p] && mask_en_q[2*p+1] && mask_val_q[2*p]
				&& mask_val_q[2*p+1]) begin
				soft_mask[2*p+:2] = 2'b00;
			end
		end
		mask_out = mode_q[MODE_MASK_SEL] ? soft_mask : hw_mask_in;
		ovr_out = mask_out;
		if (mode_q[MODE_BRAKE]) begin
			ovr_out = 6'b101010;
		end else if (protect_in) begin
			ovr_out = mode_q[MODE_PROT_SEL] ? 6'b101010 : 6'b000000;
		end
	end

	// ------------------------------------------------------------
	// Dead-time prescaler and per-channel rising-edge delay
	// ------------------------------------------------------------
	logic [2:0] pre_q, pre_d;
	logic dt_tick;
	always_comb begin
		pre_d = pre_q + 3'h1;
		unique case (dts_q[DT_CLK_LSB+:2])
			2'h0: dt_tick = 1'b1;
			2'h1: dt_tick = pre_q[0];
			2'h2: dt_tick = &pre_q[1:0];
			default: dt_tick = &pre_q;
		endcase
	end

	bgd_dt_e st_q [6];
	bgd_dt_e st_d [6];
	logic [4:0] cnt_q [6];
	logic [4:0] cnt_d [6];
	logic [5:0] dt_out;
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			st_d[i] = st_q[i];
			cnt_d[i] = cnt_q[i];
			if (!dts_q[DT_EN_BIT]) begin
				st_d[i] = ovr_out[i] ? DT_HIGH : DT_IDLE;
			end else begin
				unique case (st_q[i])
					DT_IDLE: if (ovr_out[i]) begin
						st_d[i] = DT_WAIT;
						cnt_d[i] = 5'h00;
					end
					DT_WAIT: if (!ovr_out[i]) begin
						st_d[i] = DT_IDLE;
					end else if (dt_tick) begin
						// Count ticks 0..N, so N+1 periods
						if (cnt_q[i] == dts_q[4:0]) st_d[i] = DT_HIGH;
						else cnt_d[i] = cnt_q[i] + 5'h01;
					end
					DT_HIGH: if (!ovr_out[i]) st_d[i] = DT_IDLE;
				endcase
			end
			// Falling edge drops immediately
			dt_out[i] = dts_q[DT_EN_BIT] ? ((st_q[i] == DT_HIGH) && ovr_out[i])
				: ovr_out[i];
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pre_q <= 3'h0;
			for (int i = 0; i < 6; i++) begin
				st_q[i] <= DT_IDLE;
				cnt_q[i] <= 5'h00;
			end
		end else begin
			pre_q <= pre_d;
			for (int i = 0; i < 6; i++) begin
				st_q[i] <= st_d[i];
				cnt_q[i] <= cnt_d[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Stagger, polarity and pins
	// ------------------------------------------------------------
	logic [5:0] stag, pin_d, pin_q;
	bgd_gate_s pins;
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			stag[2*p+:2] = (&dt_out[2*p+:2]) ? 2'b00 : dt_out[2*p+:2];
		end
		// 1 means transistor on before polarity
		pin_d = stag ^ pol_q[5:0];
	end
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) pin_q <= 6'h00;
		else pin_q <= pin_d;
	end
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			pins.high[p] = pin_q[2*p];
			pins.low[p] = pin_q[2*p+1];
		end
	end
	assign gate_high_pins_out = pins.high;
	assign gate_low_pins_out = pins.low;
	assign gate_oe_out = {6{oe_q}};

	// ------------------------------------------------------------
	// Hall source, noise filter, delay
	// ------------------------------------------------------------
	logic [2:0] samp_q, samp_d;
	logic [4:0] hcnt_q, hcnt_d;
	logic [2:0] buf1_q, buf1_d, buf2_q, buf2_d, hout_q, hout_d;
	logic samp_tick;
	always_comb begin
		logic [2:0] raw;
		raw = hctl_q[HC_SRC_SEL] ? hall_cmp_in : hall_pin_in;
		// Sample tick every 2^sel clocks, every 8 clocks for sel 3 and above
		samp_d = samp_q + 3'h1;
		samp_tick = (samp_q & ((3'h1 << hflt_q[HF_RATE_LSB+:3]) - 3'h1)) == 3'h0;
		filt_d = filt_q;
		hcnt_d = hcnt_q;
		if (!hctl_q[HC_FILT_EN]) begin
			filt_d = raw;
			hcnt_d = 5'h00;
		end else if (samp_tick) begin
			if (raw == filt_q) hcnt_d = 5'h00;
			else if (hcnt_q >= hflt_q[4:0]) begin
				filt_d = raw;
				hcnt_d = 5'h00;
			end else hcnt_d = hcnt_q + 5'h01;
		end
		// Soft Hall C lives in the mode register: the Hall byte has no room
		hall_sel = hctl_q[HC_SRC_MODE] ? filt_q
			: {mode_q[MODE_SOFT_C], hctl_q[HC_SOFT_LSB+:2]};
		buf1_d = buf1_q;
		buf2_d = buf2_q;
		if (!hctl_q[HC_DELAY_SEL]) begin
			buf1_d = 3'h0;
			buf2_d = 3'h0;
			hout_d = hall_sel;
		end else begin
			if (hall_sel != buf1_q) buf1_d = hall_sel;
			if (timer_match_in) buf2_d = buf1_q;
			hout_d = buf2_q;
		end
		hall_st = hctl_q[HC_DELAY_SEL] && (buf1_q != buf2_q);
	end
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			samp_q <= 3'h0;
			hcnt_q <= 5'h00;
			filt_q <= 3'h0;
			buf1_q <= 3'h0;
			buf2_q <= 3'h0;
			hout_q <= 3'h0;
		end else begin
			samp_q <= samp_d;
			hcnt_q <= hcnt_d;
			filt_q <= filt_d;
			buf1_q <= buf1_d;
			buf2_q <= buf2_d;
			hout_q <= hout_d;
		end
	end
	assign hall_decode_out = hout_q;
	// Run bit driven for selected timer while a change is pending
	always_comb begin
		timer_run_bit_out = 3'h0;
		if (hctl_q[HC_TMR_LSB+:2] != TMR_UNUSED) begin
			timer_run_bit_out[hctl_q[HC_TMR_LSB+:2]] = hall_st;
		end
	end
endmodule // bgd_top
`default_nettype wire

// >>> test/bgd_partner.sv
// Partner: Hall sensor wheel and gate driver transistor pairs
`timescale 1ns/1ps
`default_nettype none
module bgd_partner (
	input wire logic clk_in,
	input wire logic step_in,
	input wire logic [2:0] high_in,
	input wire logic [2:0] low_in,
	input wire logic [5:0] oe_in,
	output logic [2:0] hall_out,
	output logic [2:0] cmp_out,
	output logic shoot_out
);
	logic [2:0] pos_q = 3'h0;
	logic [2:0] code [6] = '{3'h1, 3'h3, 3'h7, 3'h6, 3'h4, 3'h0};
	// One step per request, six to a cycle; delays stay inside one step
	always @(posedge clk_in)
		if (step_in)
			pos_q <= (pos_q == 3'h5) ? 3'h0 : pos_q + 3'h1;
	assign hall_out = code[pos_q];
	assign cmp_out = ~code[pos_q];
	// N-type pairs: a 1 turns a transistor on, both on is a short
	assign shoot_out = |oe_in && |(high_in & low_in);
endmodule // bgd_partner
`default_nettype wire

// >>> test/bgd_checker.sv
// Checker: port-level assertions for the gate conditioning block
`timescale 1ns/1ps
`default_nettype none
module bgd_checker
	import bgd_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic avs_waitrequest_out,
	input wire logic [5:0] pwm_gen_in,
	input wire logic [5:0] hw_mask_in,
	input wire logic protect_in,
	input wire logic [2:0] gate_high_pins_out,
	input wire logic [2:0] gate_low_pins_out,
	input wire logic [5:0] gate_oe_out,
	input wire logic [2:0] hall_decode_out,
	input wire logic [2:0] timer_run_bit_out
);
	logic [7:0] r_q [8];
	logic [7:0] r_d [8];
	logic [5:0] s1_q, s2_q, x;
	logic [3:0] q_q, q_d;
	logic pol_q, pol_d;
	wire tk = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
	wire qt = q_q > 4'h2;
	wire [5:0] pn = {gate_low_pins_out[2], gate_high_pins_out[2], gate_low_pins_out[1],
		gate_high_pins_out[1], gate_low_pins_out[0], gate_high_pins_out[0]} ^ r_q[3][5:0];
	wire [5:0] e = s1_q & ~{{2{&s1_q[5:4]}}, {2{&s1_q[3:2]}}, {2{&s1_q[1:0]}}};
	wire [2:0] rm = (r_q[5][3] && r_q[5][5:4] != TMR_UNUSED) ? 3'h1 << r_q[5][5:4] : 3'h0;
	// Shadow registers: the mode is known only from the writes seen
	always_comb begin
		r_d = r_q;
		if (tk && avs_address_in < ADDR_STATUS)
			r_d[avs_address_in[2:0]] = avs_writedata_in[7:0];
		q_d = tk ? 4'h0 : q_q + {3'h0, q_q != 4'hf};
		pol_d = pol_q || (tk && avs_address_in == ADDR_POLARITY);
		x = r_q[4][0] ? ((r_q[0][5:0] & r_q[1][5:0]) | (~r_q[0][5:0] & pwm_gen_in)) : hw_mask_in;
		if (r_q[4][1] || (protect_in && r_q[4][2]))
			x = 6'h2a;
		else if (protect_in)
			x = 6'h00;
	end
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			r_q <= '{default: 8'h00};
			{s1_q, s2_q, q_q, pol_q} <= '0;
		end else begin
			r_q <= r_d;
			{s1_q, s2_q, q_q, pol_q} <= {x, s1_q, q_d, pol_d};
		end
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	a_hiz_reset: assert property (!pol_q |-> gate_oe_out == 6'h00)
		else $error("gate pins driven early");
	a_model_pass: assert property (qt && !r_q[2][5] |-> pn == e)
		else $error("pin levels wrong");
	a_fall_fast: assert property (qt |-> (pn & ~s1_q) == 6'h00)
		else $error("falling edge late");
	a_no_shoot: assert property (qt |-> !(|(pn[4:0] & pn[5:1] & 5'h15)))
		else $error("pair both on");
	a_brake_high: assert property (qt && r_q[4][1] |->
		gate_high_pins_out == {r_q[3][4], r_q[3][2], r_q[3][0]}) else $error("brake high side on");
	a_prot_free: assert property (protect_in [*3] ##0 (qt && r_q[4][2:1] == 2'h0) |-> pn == 6'h00)
		else $error("protect not free running");
	a_hall_soft: assert property (qt && !r_q[5][0] |-> hall_decode_out[1:0] == r_q[5][7:6])
		else $error("soft hall not used");
	a_run_sel: assert property (qt |-> (timer_run_bit_out & ~rm) == 3'h0)
		else $error("wrong timer run bit");
	c_brake: cover property (qt && r_q[4][1]);
	c_prot: cover property (qt && protect_in && r_q[4][2]);
	c_dt: cover property (qt && r_q[2][5] && $rose(gate_high_pins_out[0]));
endmodule // bgd_checker
bind bgd_top bgd_checker bgd_checker_inst (.*);
`default_nettype wire

// >>> test/testbench.sv
// Testbench: register driven checks of gate conditioning and Hall path
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
	import bgd_pkg::*;
	logic core_clk_in = 0, rst_in = 1, avs_read_in = 0, avs_write_in = 0, protect_in = 0;
	logic timer_match_in = 0, avs_waitrequest_out, step = 0, shoot, shot = 0;
	logic [3:0] avs_address_in = 0, avs_byteenable_in = 4'h1;
	logic [31:0] avs_writedata_in = 0, avs_readdata_out, q;
	logic [5:0] pwm_gen_in = 0, hw_mask_in = 0, gate_oe_out;
	logic [2:0] hall_pin_in, hall_cmp_in, gate_high_pins_out, gate_low_pins_out;
	logic [2:0] hall_decode_out, timer_run_bit_out;
	logic [7:0] ovm [4] = '{8'h01, 8'h05, 8'h03, 8'h03};
	logic [5:0] ovx [4] = '{6'h00, 6'h2a, 6'h2a, 6'h2a};
	wire [5:0] pn = {gate_low_pins_out[2], gate_high_pins_out[2], gate_low_pins_out[1],
		gate_high_pins_out[1], gate_low_pins_out[0], gate_high_pins_out[0]};
	int err_count = 0, num_checks = 0, b, d;
	bgd_top bgd_top_inst (.*);
	bgd_partner bgd_partner_inst (.clk_in(core_clk_in), .step_in(step),
		.high_in(gate_high_pins_out), .low_in(gate_low_pins_out), .oe_in(gate_oe_out),
		.hall_out(hall_pin_in), .cmp_out(hall_cmp_in), .shoot_out(shoot));
	initial forever #50 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) if (shoot) shot <= 1'b1;
	// ------
	// Bus and pin tasks
	// ------
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
		avs_write_in <= w;
		avs_read_in <= !w;
		avs_address_in <= a;
		avs_writedata_in <= {24'h000000, v};
		@(posedge core_clk_in);
		while (avs_waitrequest_out) @(posedge core_clk_in);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		// Extra edge so the next request never lands in the release step
		@(posedge core_clk_in);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		`CK("readback", {24'h000000, e}, q)
	endtask
	task automatic pins(input logic [5:0] e);
		repeat (3) @(posedge core_clk_in);
		`CK("pins", e, pn)
	endtask
	task automatic meas(input logic lv, output int c);
		c = 0;
		while (gate_high_pins_out[0] !== lv && c < 500) begin
			@(posedge core_clk_in);
			c++;
		end
	endtask
	task automatic stp();
		step <= 1'b1;
		@(posedge core_clk_in);
		step <= 1'b0;
		repeat (4) @(posedge core_clk_in);
	endtask
	function automatic logic [5:0] stg(input logic [5:0] v);
		for (int p = 0; p < 3; p++) if (v[2*p] && v[2*p+1]) v[2*p+:2] = 2'h0;
		return v;
	endfunction
	task automatic results();
		if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#5000000;
		err_count++;
		results();
	end
	initial begin
		repeat (10) @(posedge core_clk_in);
		rst_in <= 1'b0;
		@(posedge core_clk_in);
		`CK("oe", 6'h00, gate_oe_out)
		for (int i = 0; i < 4; i++) begin
			rdc(4'(i), 8'h00);
			acc(1'b1, 4'(i), 8'hff);
			rdc(4'(i), i == 2 ? 8'hff : 8'h3f);
			acc(1'b1, 4'(i), 8'h00);
		end
		acc(1'b1, 4'hc, 8'h55);
		rdc(4'hc, 8'h00);
		`CK("oe", 6'h3f, gate_oe_out)
		shot <= 1'b0;
		acc(1'b1, ADDR_MODE_CTRL, 8'h01);
		acc(1'b1, ADDR_MASK_EN, 8'h3f);
		for (int v = 0; v < 64; v++) begin
			acc(1'b1, ADDR_MASK_VAL, 8'(v));
			pins(stg(6'(v)));
		end
		pwm_gen_in <= 6'h15;
		acc(1'b1, ADDR_MASK_EN, 8'h03);
		acc(1'b1, ADDR_MASK_VAL, 8'h02);
		pins(6'h16);
		hw_mask_in <= 6'h21;
		acc(1'b1, ADDR_MODE_CTRL, 8'h00);
		pins(6'h21);
		acc(1'b1, ADDR_MODE_CTRL, 8'h01);
		acc(1'b1, ADDR_MASK_EN, 8'h3f);
		acc(1'b1, ADDR_MASK_VAL, 8'h00);
		for (int i = 0; i < 6; i++) begin
			acc(1'b1, ADDR_POLARITY, 8'h01 << i);
			pins(6'h01 << i);
		end
		acc(1'b1, ADDR_POLARITY, 8'h00);
		acc(1'b1, ADDR_MASK_VAL, 8'h15);
		for (int i = 0; i < 4; i++) begin
			protect_in <= (i != 2);
			acc(1'b1, ADDR_MODE_CTRL, ovm[i]);
			pins(ovx[i]);
		end
		protect_in <= 1'b0;
		acc(1'b1, ADDR_MODE_CTRL, 8'h01);
		acc(1'b1, ADDR_MASK_VAL, 8'h00);
		for (int i = 0; i < 5; i++) begin
			acc(1'b1, ADDR_DEAD_TIME, i == 0 ? 8'h00 : 8'(((i - 1) << 6) | 8'h23));
			acc(1'b1, ADDR_MASK_VAL, 8'h01);
			meas(1'b1, d);
			if (i == 0) b = d;
			else `CK("dead time", 1'b1, (d - b >= 3 * (1 << (i - 1)) + 2) && (d - b <= 4 * (1 << (i - 1)) + 1))
			acc(1'b1, ADDR_MASK_VAL, 8'h00);
			meas(1'b0, d);
			`CK("fall delay", b, d)
		end
		acc(1'b1, ADDR_DEAD_TIME, 8'h00);
		`CK("shoot", 1'b0, shot)
		acc(1'b1, ADDR_HALL_CTRL, 8'hc0);
		repeat (3) @(posedge core_clk_in);
		`CK("soft hall", 2'h3, hall_decode_out[1:0])
		for (int i = 0; i < 12; i++) begin
			if (i % 6 == 0) acc(1'b1, ADDR_HALL_CTRL, i < 6 ? 8'h01 : 8'h03);
			stp();
			`CK("hall", i < 6 ? hall_pin_in : hall_cmp_in, hall_decode_out)
		end
		for (int t = 0; t < 4; t++) begin
			acc(1'b1, ADDR_HALL_CTRL, 8'(t << 4) | 8'h09);
			stp();
			`CK("run", t < 3 ? 3'h1 << t : 3'h0, timer_run_bit_out)
			timer_match_in <= 1'b1;
			@(posedge core_clk_in);
			timer_match_in <= 1'b0;
			repeat (4) @(posedge core_clk_in);
			`CK("run idle", 3'h0, timer_run_bit_out)
			if (t < 3) `CK("delayed hall", hall_pin_in, hall_decode_out)
		end
		acc(1'b1, ADDR_HALL_CTRL, 8'h00);
		repeat (4) @(posedge core_clk_in);
		`CK("run off", 3'h0, timer_run_bit_out)
		results();
	end
endmodule // testbench
`default_nettype wire
